// ### cav_params.svh
//////////////////////////////////////////////////////////////////////////////
// Purpose : register addresses and reset values of the counter array
//           value registers
// Assumes : 8-bit special-function register bus, byte addresses
// Notes   : definitions only
//////////////////////////////////////////////////////////////////////////////
`ifndef CAV_PARAMS_SVH
`define CAV_PARAMS_SVH

// counter byte addresses
`define CAV_ADDR_CNT_LO  8'hF9
`define CAV_ADDR_CNT_HI  8'hFA

// compare low byte addresses, channels 0 to 5
`define CAV_ADDR_CPL0    8'hFB
`define CAV_ADDR_CPL1    8'hE9
`define CAV_ADDR_CPL2    8'hEB
`define CAV_ADDR_CPL3    8'hED
`define CAV_ADDR_CPL4    8'hFD
`define CAV_ADDR_CPL5    8'hD2

// compare high byte addresses, channels 0 to 5
`define CAV_ADDR_CPH0    8'hFC
`define CAV_ADDR_CPH1    8'hEA
`define CAV_ADDR_CPH2    8'hEC
`define CAV_ADDR_CPH3    8'hEE
`define CAV_ADDR_CPH4    8'hFE
`define CAV_ADDR_CPH5    8'hD3

// reset values and read value of an unmapped address
`define CAV_RST_BYTE     8'h00
`define CAV_RST_WORD     16'h0000
`define CAV_RD_UNMAPPED  8'h00

// channel that becomes the watchdog
`define CAV_WDT_CHANNEL  5

`endif

// ### cav_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : types shared by the counter array value registers
// Assumes : six capture/compare channels
// Notes   : address and reset constants live in cav_params.svh
//////////////////////////////////////////////////////////////////////////////
package cav_pkg;

	localparam int CAV_CHANNELS = 6;

	typedef logic [7:0]  cav_byte_t;
	typedef logic [15:0] cav_word_t;

	// one bus request
	typedef struct packed {
		logic      rd;
		logic      wr;
		cav_byte_t addr;
		cav_byte_t wdata;
	} cav_sfr_req_s;

	// whole state of the register block
	typedef struct packed {
		cav_word_t                        counter;
		cav_byte_t                        snapshot;
		logic [CAV_CHANNELS-1:0][15:0]    cmp;
		logic [CAV_CHANNELS-1:0][15:0]    rld;
		logic [CAV_CHANNELS-1:0]          ecom;
		cav_byte_t                        rdata;
		logic                             wdt_lock;
	} cav_state_s;

endpackage : cav_pkg

// ### cav_regs.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : value registers of a 16-bit counter array with six
//           capture/compare channels, reached over the byte register bus
// Assumes : bus strobes are one-cycle pulses on i_core_clk; count step
//           and lock bits come from logic on the same clock
// Notes   : read data appears on the edge after the read strobe
//
// Summary of operation
// - counter high byte held, read/write, resets zero
// - high read returns snapshot loaded on low read
// - watchdog enabled blocks counter high byte writes
// - six channels, each with own low/high address
// - low byte holds value bits 7:0, resets zero
// - high byte holds value bits 15:8, resets zero
// - reload select maps low address to reload low
// - reload select maps high address to reload high
// - low byte write clears comparator enable
// - high byte write sets comparator enable
// - counter low byte held, read/write, resets zero
// - comparator enable high enables channel comparison
// - watchdog enabled locks channel five mode register
//////////////////////////////////////////////////////////////////////////////
`include "cav_params.svh"

module cav_regs
	import cav_pkg::*;
#(
	parameter int CHANNELS = CAV_CHANNELS
) (
	// clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_reset,
	// register bus
	input  wire logic                     i_sfr_rd,
	input  wire logic                     i_sfr_wr,
	input  wire logic [7:0]               i_sfr_addr,
	input  wire logic [7:0]               i_sfr_wdata,
	output logic      [7:0]               o_sfr_rdata,
	// control bits from the mode logic
	input  wire logic                     i_watchdog_enable_bit,
	input  wire logic                     i_reload_select_bit,
	input  wire logic                     i_count_step,
	// values to the counting and match logic
	output logic      [15:0]              o_counter,
	output logic      [CHANNELS-1:0][15:0] o_compare_value,
	output logic      [CHANNELS-1:0][15:0] o_reload_value,
	output logic      [CHANNELS-1:0]      o_comparator_function_enable,
	output logic                          o_module5_mode_lock
);

	//////////////////////////////////////////////////////////////////////////
	// address tables
	localparam logic [5:0][7:0] LO_ADDR = {
		`CAV_ADDR_CPL5, `CAV_ADDR_CPL4, `CAV_ADDR_CPL3,
		`CAV_ADDR_CPL2, `CAV_ADDR_CPL1, `CAV_ADDR_CPL0};
	localparam logic [5:0][7:0] HI_ADDR = {
		`CAV_ADDR_CPH5, `CAV_ADDR_CPH4, `CAV_ADDR_CPH3,
		`CAV_ADDR_CPH2, `CAV_ADDR_CPH1, `CAV_ADDR_CPH0};

	cav_sfr_req_s         req;
	cav_state_s           state_reg;
	cav_state_s           state_next;
	logic [CHANNELS-1:0]  lo_sel;
	logic [CHANNELS-1:0]  hi_sel;
	logic [2:0]           lo_idx;
	logic [2:0]           hi_idx;
	logic                 cnt_lo_sel;
	logic                 cnt_hi_sel;
	logic [15:0]          cnt_step;

	// gather the bus request
	assign req.rd    = i_sfr_rd;
	assign req.wr    = i_sfr_wr;
	assign req.addr  = i_sfr_addr;
	assign req.wdata = i_sfr_wdata;

	//////////////////////////////////////////////////////////////////////////
	// address decode: one select per channel byte
	always_comb begin
		lo_sel = '0;
		hi_sel = '0;
		lo_idx = 3'h0;
		hi_idx = 3'h0;
		for (int k = 0; k < CHANNELS; k++) begin
			if (req.addr == LO_ADDR[k]) begin
				lo_sel[k] = 1'b1;
				lo_idx    = 3'(k);
			end
			if (req.addr == HI_ADDR[k]) begin
				hi_sel[k] = 1'b1;
				hi_idx    = 3'(k);
			end
		end
	end

	assign cnt_lo_sel = (req.addr == `CAV_ADDR_CNT_LO);
	assign cnt_hi_sel = (req.addr == `CAV_ADDR_CNT_HI);
	assign cnt_step   = state_reg.counter + {15'h0000, i_count_step};

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_next          = state_reg;
		state_next.wdt_lock = i_watchdog_enable_bit;
		state_next.counter  = cnt_step;
		// counter bytes, writes blocked while the watchdog runs
		if (req.wr && cnt_lo_sel && !i_watchdog_enable_bit) begin
			state_next.counter[7:0] = req.wdata;
		end
		if (req.wr && cnt_hi_sel && !i_watchdog_enable_bit) begin
			state_next.counter[15:8] = req.wdata;
		end
		// channel bytes: compare value or reload value
		for (int k = 0; k < CHANNELS; k++) begin
			if (req.wr && lo_sel[k]) begin
				state_next.ecom[k] = 1'b0;
				if (i_reload_select_bit) begin
					state_next.rld[k][7:0] = req.wdata;
				end else begin
					state_next.cmp[k][7:0] = req.wdata;
				end
			end
			if (req.wr && hi_sel[k]) begin
				state_next.ecom[k] = 1'b1;
				if (i_reload_select_bit) begin
					state_next.rld[k][15:8] = req.wdata;
				end else begin
					state_next.cmp[k][15:8] = req.wdata;
				end
			end
		end
		// reads: low byte is live and freezes the high byte
		if (req.rd) begin
			state_next.rdata = `CAV_RD_UNMAPPED;
			if (cnt_lo_sel) begin
				state_next.rdata    = state_reg.counter[7:0];
				state_next.snapshot = state_reg.counter[15:8];
			end
			if (cnt_hi_sel) begin
				state_next.rdata = state_reg.snapshot;
			end
			if (|lo_sel) begin
				state_next.rdata = i_reload_select_bit ?
					state_reg.rld[lo_idx][7:0] :
					state_reg.cmp[lo_idx][7:0];
			end
			if (|hi_sel) begin
				state_next.rdata = i_reload_select_bit ?
					state_reg.rld[hi_idx][15:8] :
					state_reg.cmp[hi_idx][15:8];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_reg.counter  <= `CAV_RST_WORD;
			state_reg.snapshot <= `CAV_RST_BYTE;
			state_reg.cmp      <= '0;
			state_reg.rld      <= '0;
			state_reg.ecom     <= '0;
			state_reg.rdata    <= `CAV_RST_BYTE;
			state_reg.wdt_lock <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign o_sfr_rdata                  = state_reg.rdata;
	assign o_counter                    = state_reg.counter;
	assign o_compare_value              = state_reg.cmp;
	assign o_reload_value               = state_reg.rld;
	assign o_comparator_function_enable = state_reg.ecom;
	assign o_module5_mode_lock          = state_reg.wdt_lock;

	//////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	sequence seq_lo_read;
		req.rd && cnt_lo_sel;
	endsequence

	sequence seq_hi_read;
		req.rd && cnt_hi_sel;
	endsequence

	sequence seq_hi_locked_write;
		req.wr && cnt_hi_sel && i_watchdog_enable_bit && !i_count_step;
	endsequence

	sequence seq_cmp_lo_write;
		req.wr && (|lo_sel) && !i_reload_select_bit;
	endsequence

	sequence seq_rld_hi_write;
		req.wr && (|hi_sel) && i_reload_select_bit;
	endsequence

	sequence seq_rld_lo_write;
		req.wr && (|lo_sel) && i_reload_select_bit;
	endsequence

	sequence seq_cmp_hi_write;
		req.wr && (|hi_sel) && !i_reload_select_bit;
	endsequence

	sequence seq_cnt_lo_write;
		req.wr && cnt_lo_sel && !i_watchdog_enable_bit;
	endsequence

	sequence seq_lo_locked_write;
		req.wr && cnt_lo_sel && i_watchdog_enable_bit && !i_count_step;
	endsequence

	AST_SNAP_LOAD: assert property (
		seq_lo_read |=> state_reg.snapshot == $past(o_counter[15:8]))
		else $error("snapshot not loaded on counter low read");

	AST_SNAP_HOLD: assert property (
		!(req.rd && cnt_lo_sel) |=> $stable(state_reg.snapshot))
		else $error("snapshot changed without counter low read");

	AST_HI_READ: assert property (
		seq_lo_read ##1 (!req.rd [*3]) ##1 seq_hi_read
		|=> o_sfr_rdata == $past(o_counter[15:8], 5))
		else $error("counter high read did not return snapshot");

	AST_WDT_LOCK: assert property (
		seq_hi_locked_write |=> $stable(o_counter[15:8]))
		else $error("counter high changed while watchdog enabled");

	AST_HI_WRITE: assert property (
		req.wr && cnt_hi_sel && !i_watchdog_enable_bit
		|=> o_counter[15:8] == $past(req.wdata))
		else $error("counter high write lost");

	AST_LO_CLEARS_ECOM: assert property (
		req.wr && (|lo_sel) && !(|hi_sel)
		|=> (o_comparator_function_enable & $past(lo_sel)) == '0)
		else $error("low byte write did not clear comparator enable");

	AST_HI_SETS_ECOM: assert property (
		req.wr && (|hi_sel)
		|=> (o_comparator_function_enable & $past(hi_sel)) == $past(hi_sel))
		else $error("high byte write did not set comparator enable");

	AST_CMP_LO_WRITE: assert property (
		seq_cmp_lo_write
		|=> o_compare_value[$past(lo_idx)][7:0] == $past(req.wdata))
		else $error("compare low byte not written");

	AST_RLD_HI_WRITE: assert property (
		seq_rld_hi_write
		|=> o_reload_value[$past(hi_idx)][15:8] == $past(req.wdata)
		&& $stable(o_compare_value))
		else $error("reload high byte not written or compare disturbed");

	AST_MODE_LOCK: assert property (
		##1 o_module5_mode_lock == $past(i_watchdog_enable_bit))
		else $error("mode lock does not follow watchdog enable");

	AST_RLD_LO_WRITE: assert property (
		seq_rld_lo_write
		|=> o_reload_value[$past(lo_idx)][7:0] == $past(req.wdata)
		&& $stable(o_compare_value))
		else $error("reload low byte not written or compare disturbed");

	AST_CMP_HI_WRITE: assert property (
		seq_cmp_hi_write
		|=> o_compare_value[$past(hi_idx)][15:8] == $past(req.wdata)
		&& $stable(o_reload_value))
		else $error("compare high byte not written or reload disturbed");

	AST_LO_WRITE: assert property (
		seq_cnt_lo_write |=> o_counter[7:0] == $past(req.wdata))
		else $error("counter low write lost");

	AST_LO_LOCK: assert property (
		seq_lo_locked_write |=> $stable(o_counter))
		else $error("counter changed by write while watchdog enabled");

	AST_LO_READ: assert property (
		seq_lo_read |=> o_sfr_rdata == $past(o_counter[7:0]))
		else $error("counter low read did not return live low byte");

	AST_RDATA_HOLD: assert property (
		!req.rd |=> $stable(o_sfr_rdata))
		else $error("read data changed without a read");

	AST_COUNT_STEP: assert property (
		!req.wr && i_count_step
		|=> o_counter == $past(o_counter) + 16'h0001)
		else $error("counter did not step");

	AST_ECOM_HOLD: assert property (
		!req.wr |=> $stable(o_comparator_function_enable))
		else $error("comparator enable changed without a write");

endmodule : cav_regs

// ### cav_regs_test.sv
// Purpose : self-checking bench of the counter array value registers
// Assumes : strobes driven at the falling edge, read data one edge later
// Notes   : read expectations queue up and a watcher pops them
`include "cav_params.svh"

module cav_regs_test
	import cav_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////
	logic               core_clk = 0;
	logic               reset    = 1;
	logic               rd = 0, wr = 0, wdt = 0, rsel = 0, step = 0;
	logic [7:0]         addr = 8'h00, wd = 8'h00;
	logic [7:0]         rdata;
	logic [15:0]        cnt;
	logic [5:0][15:0]   cmpv, rldv;
	logic [5:0]         en;
	logic               lock, rd_pend;
	logic [7:0]         exp_q[$];
	logic [15:0]        cm[6];
	logic [31:0]        seed = 32'h087F4CCF;
	int                 mismatches = 0, checked = 0;
	logic [7:0] lo_a[6] = '{`CAV_ADDR_CPL0, `CAV_ADDR_CPL1, `CAV_ADDR_CPL2,
		`CAV_ADDR_CPL3, `CAV_ADDR_CPL4, `CAV_ADDR_CPL5};
	logic [7:0] hi_a[6] = '{`CAV_ADDR_CPH0, `CAV_ADDR_CPH1, `CAV_ADDR_CPH2,
		`CAV_ADDR_CPH3, `CAV_ADDR_CPH4, `CAV_ADDR_CPH5};

	// clock, 4 ns period
	always #2 core_clk = ~core_clk;

	cav_regs dut_u (
		.i_core_clk(core_clk), .i_reset(reset), .i_sfr_rd(rd),
		.i_sfr_wr(wr), .i_sfr_addr(addr), .i_sfr_wdata(wd),
		.o_sfr_rdata(rdata), .i_watchdog_enable_bit(wdt),
		.i_reload_select_bit(rsel), .i_count_step(step),
		.o_counter(cnt), .o_compare_value(cmpv), .o_reload_value(rldv),
		.o_comparator_function_enable(en), .o_module5_mode_lock(lock));

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one bus access; a read notes its expected byte
	task automatic acc(input logic r, input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [7:0] e);
		@(negedge core_clk);
		rd = r;
		wr = w;
		addr = a;
		wd = d;
		if (r) exp_q.push_back(e);
		@(negedge core_clk);
		rd = 0;
		wr = 0;
	endtask : acc

	task automatic close_out;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	// read watcher: data settles after the edge that took the strobe
	always @(posedge core_clk) rd_pend <= rd & ~reset;
	always @(negedge core_clk) begin
		if (rd_pend === 1'b1) begin
			if (exp_q.size() == 0) chk({8'h00, rdata}, 16'hFFFF);
			else chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
		end
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge core_clk);
		reset = 0;
		for (int c = 0; c < 6; c++) begin
			acc(1, 0, lo_a[c], 0, 8'h00);
			acc(1, 0, hi_a[c], 0, 8'h00);
			chk({15'h0, en[c]}, 16'h0000);
		end
		acc(1, 0, `CAV_ADDR_CNT_LO, 0, 8'h00);
		acc(1, 0, `CAV_ADDR_CNT_HI, 0, 8'h00);
		acc(1, 0, 8'h80, 0, `CAV_RD_UNMAPPED);
		$display("test reset values done");
		for (int s = 0; s < 2; s++) begin
			rsel = s[0];
			for (int c = 0; c < 6; c++) begin
				seed = xs(seed);
				acc(0, 1, lo_a[c], seed[7:0], 0);
				chk({15'h0, en[c]}, 16'h0000);
				acc(0, 1, hi_a[c], seed[15:8], 0);
				chk({15'h0, en[c]}, 16'h0001);
				if (s == 0) cm[c] = seed[15:0];
				if (s == 0) chk(cmpv[c], seed[15:0]);
				else chk(rldv[c], seed[15:0]);
				acc(1, 0, lo_a[c], 0, seed[7:0]);
				acc(1, 0, hi_a[c], 0, seed[15:8]);
			end
		end
		rsel = 0;
		for (int c = 0; c < 6; c++) begin
			acc(1, 0, lo_a[c], 0, cm[c][7:0]);
			chk(cmpv[c], cm[c]);
		end
		$display("test channel bytes done");
		acc(0, 1, `CAV_ADDR_CNT_LO, 8'hFF, 0);
		acc(0, 1, `CAV_ADDR_CNT_HI, 8'h12, 0);
		chk(cnt, 16'h12FF);
		step = 1;
		@(negedge core_clk);
		step = 0;
		chk(cnt, 16'h1300);
		acc(1, 0, `CAV_ADDR_CNT_HI, 0, 8'h00);
		acc(1, 0, `CAV_ADDR_CNT_LO, 0, 8'h00);
		acc(0, 1, `CAV_ADDR_CNT_HI, 8'h55, 0);
		acc(1, 0, `CAV_ADDR_CNT_HI, 0, 8'h13);
		$display("test snapshot done");
		wdt = 1;
		acc(0, 1, `CAV_ADDR_CNT_HI, 8'hAA, 0);
		acc(0, 1, `CAV_ADDR_CNT_LO, 8'hBB, 0);
		chk(cnt, 16'h5500);
		chk({15'h0, lock}, 16'h0001);
		wdt = 0;
		acc(0, 1, `CAV_ADDR_CNT_HI, 8'hAA, 0);
		chk(cnt, 16'hAA00);
		chk({15'h0, lock}, 16'h0000);
		$display("test watchdog lock done");
		reset = 1;
		repeat (2) @(negedge core_clk);
		reset = 0;
		@(negedge core_clk);
		chk(cnt, 16'h0000);
		chk(cmpv[0], 16'h0000);
		chk(rldv[0], 16'h0000);
		chk({10'h000, en}, 16'h0000);
		chk({8'h00, rdata}, 16'h0000);
		acc(1, 0, `CAV_ADDR_CNT_HI, 0, 8'h00);
		$display("test mid-run reset done");
		for (int i = 0; i < 4 && exp_q.size() != 0; i++) @(negedge core_clk);
		if (exp_q.size() != 0) mismatches++;
		close_out();
	end

endmodule : cav_regs_test
